// ==== cmwc_top.sv ====
// Mode and wake control of a CAN transceiver
`include "cmwc_regs.svh"
`default_nettype none
module cmwc_top
  import cmwc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [2:0] sys_mode_in,
  input wire logic ot_forced_in,
  input wire logic wake_pin_in,
  input wire logic bus_dom_in,
  input wire logic vcc_ok_in,
  input wire logic txd_pin_in,
  input wire logic sck_pin_in,
  input wire logic sdi_pin_in,
  input wire logic transmitter_enable_pin_in,
  input wire logic irq_pending_in,
  input wire logic rising_wake_enable_in,
  input wire logic falling_wake_enable_in,
  input wire logic wake_filter_select_in,
  input wire logic selective_config_valid_in,
  input wire logic selective_wake_enable_in,
  input wire logic bus_wake_enable_in,
  input wire logic bus_pattern_select_in,
  input wire logic low_power_listen_in,
  input wire logic bias_source_select_in,
  output logic rxd_out,
  output logic rxd_oe_out,
  output logic pullup_en_out,
  output logic txen_low_out,
  output logic sck_rep_out,
  output logic sdi_rep_out,
  output logic supply_switch_output_out,
  output logic spi_on_out,
  output logic local_wake_on_out,
  output logic bus_wake_on_out,
  output logic pn_on_out,
  output logic overtemp_on_out,
  output logic wake_rising_irq_out,
  output logic wake_falling_irq_out,
  output logic local_wake_out,
  output logic wake_pin_level_out,
  output logic bus_idle_event_out,
  output logic bus_wake_event_out,
  output logic [2:0] can_state_out,
  output logic tx_on_out,
  output logic tx_recessive_out,
  output logic rx_on_out,
  output logic [1:0] bias_out
);
  localparam int WAKE_SHORT = `CMWC_WAKE_SHORT_US * 20;
  localparam int WAKE_LONG = `CMWC_WAKE_LONG_US * 20;
  localparam int SILENCE = `CMWC_SILENCE_US * 20;
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // two flops each for the wake pin, bus state and supply good inputs
  logic [2:0] s1_reg, s1_next, s2_reg, s2_next;
  always_comb
  begin
    s1_next = {vcc_ok_in, bus_dom_in, wake_pin_in};
    s2_next = s1_reg;
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
    end
    else
    begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
    end
  end
  wire wake_s = s2_reg[0];
  wire bus_dom_s = s2_reg[1];
  wire vcc_ok_s = s2_reg[2];
  cmwc_sys_t sys;
  assign sys = cmwc_sys_t'(sys_mode_in);
  function automatic logic sys_inactive(input cmwc_sys_t m);
    sys_inactive = (m == CMWC_SYS_OFF) || (m == CMWC_SYS_BOOT) || (m == CMWC_SYS_CHECK);
  endfunction
  function automatic logic sys_low(input cmwc_sys_t m);
    sys_low = (m == CMWC_SYS_SLEEP) || (m == CMWC_SYS_STANDBY);
  endfunction
  // ----------------------------------------
  // Pin and function states
  // ----------------------------------------
  wire inactive = sys_inactive(sys);
  wire pn_cfg = selective_config_valid_in;
  logic rxd_reg, rxd_next;
  always_comb
  begin
    // interrupt level in low power, bus state otherwise
    if (sys_low(sys))
      rxd_next = !irq_pending_in;
    else
      rxd_next = !bus_dom_s;
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
      rxd_reg <= 1'b1;
    else
      rxd_reg <= rxd_next;
  end
  assign rxd_out = rxd_reg;
  assign rxd_oe_out = !inactive;
  // pulls, repeaters and forced low enable
  assign pullup_en_out = !inactive;
  assign txen_low_out = inactive;
  assign sck_rep_out = inactive ? 1'b0 : sck_pin_in;
  assign sdi_rep_out = inactive ? 1'b0 : sdi_pin_in;
  // supply switch per low power level
  assign supply_switch_output_out = !inactive && (sys != CMWC_SYS_SLEEP);
  assign spi_on_out = !inactive;
  assign local_wake_on_out = !inactive;
  assign bus_wake_on_out = sys_low(sys) && !pn_cfg;
  assign pn_on_out = !inactive && pn_cfg;
  // overtemperature monitor only in Normal, or in Listen while forced
  assign overtemp_on_out = (sys == CMWC_SYS_NORMAL) || (sys == CMWC_SYS_LISTEN && ot_forced_in);
  // ----------------------------------------
  // Local wake filter
  // ----------------------------------------
  logic stable_reg, stable_next, last_reg, last_next;
  logic [9:0] wcnt_reg, wcnt_next;
  logic rise_reg, rise_next, fall_reg, fall_next, lw_reg, lw_next;
  always_comb
  begin
    stable_next = stable_reg;
    last_next = wake_s;
    wcnt_next = (wake_s == last_reg) ? wcnt_reg + 10'h1 : 10'h0;
    rise_next = 1'b0;
    fall_next = 1'b0;
    lw_next = 1'b0;
    // accept the new level only after the filter time
    if (wake_s != stable_reg && wake_s == last_reg &&
        wcnt_reg >= 10'((wake_filter_select_in ? WAKE_LONG : WAKE_SHORT) - 1))
    begin
      stable_next = wake_s;
      wcnt_next = 10'h0;
      rise_next = wake_s && rising_wake_enable_in && !inactive;
      fall_next = !wake_s && falling_wake_enable_in && !inactive;
      lw_next = rise_next || fall_next;
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      stable_reg <= 1'b0;
      last_reg <= 1'b0;
      wcnt_reg <= 10'h0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
      lw_reg <= 1'b0;
    end
    else
    begin
      stable_reg <= stable_next;
      last_reg <= last_next;
      wcnt_reg <= wcnt_next;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
      lw_reg <= lw_next;
    end
  end
  assign wake_rising_irq_out = rise_reg;
  assign wake_falling_irq_out = fall_reg;
  assign local_wake_out = lw_reg;
  assign wake_pin_level_out = stable_reg;
  // ----------------------------------------
  // Bus silence timer
  // ----------------------------------------
  logic [15:0] idle_reg, idle_next;
  logic silent_reg, silent_next;
  always_comb
  begin
    idle_next = bus_dom_s ? 16'h0 : (silent_reg ? idle_reg : idle_reg + 16'h1);
    silent_next = !bus_dom_s && (silent_reg || idle_reg >= 16'(SILENCE));
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      idle_reg <= 16'h0;
      silent_reg <= 1'b0;
    end
    else
    begin
      idle_reg <= idle_next;
      silent_reg <= silent_next;
    end
  end
  assign bus_idle_event_out = silent_reg;
  // ----------------------------------------
  // Bus state machine
  // ----------------------------------------
  cmwc_can_t can_reg, can_next;
  logic pattern;
  logic bwake_reg, bwake_next;
  wire pat_enable = (can_reg == CMWC_CAN_OFFLINE) || (can_reg == CMWC_CAN_BIAS);
  cmwc_pattern u_pattern
  (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .enable_in(pat_enable),
    .bus_dom_in(bus_dom_s),
    .extended_in(bus_pattern_select_in),
    .pattern_out(pattern)
  );
  always_comb
  begin
    can_next = can_reg;
    bwake_next = pattern && pat_enable && bus_wake_enable_in &&
                 !(selective_wake_enable_in && pn_cfg);
    case (can_reg)
      CMWC_CAN_OFF:
        if (!inactive) can_next = CMWC_CAN_OFFLINE;
      CMWC_CAN_OFFLINE:
      begin
        // offline leaves on Normal with supply good, on Listen, or on the pattern
        if (sys == CMWC_SYS_NORMAL && vcc_ok_s) can_next = CMWC_CAN_ACTIVE;
        else if (sys == CMWC_SYS_LISTEN) can_next = CMWC_CAN_LISTEN;
        else if (pattern) can_next = CMWC_CAN_BIAS;
      end
      CMWC_CAN_BIAS:
      begin
        if (sys == CMWC_SYS_NORMAL && vcc_ok_s) can_next = CMWC_CAN_ACTIVE;
        else if (sys == CMWC_SYS_LISTEN) can_next = CMWC_CAN_LISTEN;
        else if (silent_reg) can_next = CMWC_CAN_OFFLINE;
      end
      CMWC_CAN_LISTEN:
      begin
        if (sys == CMWC_SYS_NORMAL && vcc_ok_s) can_next = CMWC_CAN_ACTIVE;
        else if (sys_low(sys)) can_next = CMWC_CAN_BIAS;
      end
      CMWC_CAN_ACTIVE:
      begin
        if (sys == CMWC_SYS_LISTEN) can_next = CMWC_CAN_LISTEN;
        else if (sys != CMWC_SYS_NORMAL || !vcc_ok_s) can_next = CMWC_CAN_BIAS;
      end
      default: can_next = CMWC_CAN_OFF;
    endcase
    if (inactive) can_next = CMWC_CAN_OFF;
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      can_reg <= CMWC_CAN_OFF;
      bwake_reg <= 1'b0;
    end
    else
    begin
      can_reg <= can_next;
      bwake_reg <= bwake_next;
    end
  end
  assign can_state_out = can_reg;
  assign bus_wake_event_out = bwake_reg;
  // ----------------------------------------
  // Transmitter, receiver and bias
  // ----------------------------------------
  wire listen = can_reg == CMWC_CAN_LISTEN;
  wire active = can_reg == CMWC_CAN_ACTIVE;
  // low power listen keeps transmitter off
  assign tx_on_out = active || (listen && !low_power_listen_in);
  assign tx_recessive_out = (listen && !low_power_listen_in) ||
                            (active && transmitter_enable_pin_in);
  // receiver only in listen and active
  assign rx_on_out = listen || active;
  always_comb
  begin
    case (can_reg)
      CMWC_CAN_OFF: bias_out = CMWC_BIAS_FLOAT;
      CMWC_CAN_OFFLINE: bias_out = CMWC_BIAS_GND;
      CMWC_CAN_BIAS: bias_out = bias_source_select_in ? CMWC_BIAS_VCC : CMWC_BIAS_BAT;
      CMWC_CAN_LISTEN:
        bias_out = (low_power_listen_in && !bias_source_select_in) ? CMWC_BIAS_BAT
                                                                   : CMWC_BIAS_VCC;
      CMWC_CAN_ACTIVE: bias_out = CMWC_BIAS_VCC;
      default: bias_out = CMWC_BIAS_FLOAT;
    endcase
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_off_priority: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    inactive |=> can_reg == CMWC_CAN_OFF) else $error("off not forced");
  a_rx_modes: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    rx_on_out == (can_reg == CMWC_CAN_LISTEN || can_reg == CMWC_CAN_ACTIVE))
    else $error("receiver state wrong");
  a_tx_off_low: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (can_reg inside {CMWC_CAN_OFF, CMWC_CAN_OFFLINE, CMWC_CAN_BIAS}) |-> !tx_on_out)
    else $error("transmitter on while offline");
  a_lpl_tx: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (listen && low_power_listen_in) |-> !tx_on_out) else $error("transmitter on in lpl");
  a_pattern_bias: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (can_reg == CMWC_CAN_OFFLINE && pattern && sys_low(sys)) |=> can_reg == CMWC_CAN_BIAS)
    else $error("pattern did not bias");
  a_rise_irq: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    rise_reg |-> stable_reg && !$past(stable_reg)) else $error("rising irq without edge");
  a_fall_irq: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    fall_reg |-> !stable_reg && $past(stable_reg)) else $error("falling irq without edge");
  a_idle_event: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    bus_dom_s |=> !silent_reg) else $error("idle event during traffic");
  a_rxd_irq: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (sys_low(sys) && irq_pending_in) |=> !rxd_reg || !sys_low(sys))
    else $error("receive output missed interrupt");
  // Wake filter: a new level is never taken before the short filter time
  sequence s_wake_early;
    wake_s != stable_reg && wcnt_reg < 10'(WAKE_SHORT - 1);
  endsequence
  a_wake_filter: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_wake_early |=> stable_reg == $past(stable_reg)) else $error("wake level taken early");
  // Bus wake gating: a blocked setup never lets an event out
  sequence s_bus_wake_blocked;
    !bus_wake_enable_in || (selective_wake_enable_in && pn_cfg) || !pat_enable;
  endsequence
  a_bus_wake_gate: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_bus_wake_blocked |=> !bwake_reg) else $error("bus wake event while blocked");
  // Bias is dropped once a low power bus has gone silent
  a_silence_exit: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (can_reg == CMWC_CAN_BIAS && silent_reg && sys_low(sys)) |=> can_reg == CMWC_CAN_OFFLINE)
    else $error("bias kept on a silent bus");
endmodule
`default_nettype wire

// ==== cmwc_regs.svh ====
// Constants for the CAN mode and wake control block
// Summary of operation
// - Pin states float or pull per mode
// - Receive output shows interrupt or bus state
// - Function enables per system mode
// - Overtemperature detection in Normal mode, and in Listen when forced
// - Rising wake edge raises rising interrupt
// - Falling wake edge raises falling interrupt
// - Wake accepted after stable filter time
// - Wake pin level readable as status
// - Bus idle event after silence timeout
// - System off overrides all bus transitions
// - Low power listen: transmitter off, battery bias unless the VCC bias source is selected
// - Transmitter state per bus mode
// - Receiver active only in listen and active
// - Bias source per bus mode and settings
// - Wake sources accepted per bus mode
// - Wake pattern moves offline to offline bias
// - Pattern wake needs enable, frame detection off
// - Select standard or extended wake pattern
// - Dominant, recessive, dominant, optional recessive phases
// - Short intervals between phases ignored
// - Pattern must finish within bus wake timeout
// - Supply switch active in standby, off in sleep
`ifndef CMWC_REGS_SVH
`define CMWC_REGS_SVH
`define CMWC_CLK_HZ 20000000
`define CMWC_MC_NORMAL 4'hf
`define CMWC_MC_STANDBY 4'h6
`define CMWC_MC_SLEEP 4'h1
`define CMWC_MC_LISTEN 4'h8
`define CMWC_WAKE_SHORT_US 10
`define CMWC_WAKE_LONG_US 40
`define CMWC_BUSDOM_NS 1000
`define CMWC_BUSREC_NS 1000
`define CMWC_TO_WAKE_US 1000
`define CMWC_SILENCE_US 1000
`define CMWC_CYC(ns) (((ns) * 20 + 999) / 1000)
`endif

// ==== cmwc_pkg.sv ====
// Types for the CAN mode and wake control block
`default_nettype none
package cmwc_pkg;
  typedef enum logic [2:0]
  {
    CMWC_SYS_OFF = 3'h0,
    CMWC_SYS_BOOT = 3'h1,
    CMWC_SYS_CHECK = 3'h3,
    CMWC_SYS_STANDBY = 3'h2,
    CMWC_SYS_SLEEP = 3'h6,
    CMWC_SYS_LISTEN = 3'h7,
    CMWC_SYS_NORMAL = 3'h5
  } cmwc_sys_t;
  typedef enum logic [2:0]
  {
    CMWC_CAN_OFF = 3'h0,
    CMWC_CAN_OFFLINE = 3'h1,
    CMWC_CAN_BIAS = 3'h3,
    CMWC_CAN_LISTEN = 3'h2,
    CMWC_CAN_ACTIVE = 3'h6
  } cmwc_can_t;
  typedef enum logic [1:0]
  {
    CMWC_BIAS_FLOAT = 2'h0,
    CMWC_BIAS_GND = 2'h1,
    CMWC_BIAS_VCC = 2'h3,
    CMWC_BIAS_BAT = 2'h2
  } cmwc_bias_t;
endpackage
`default_nettype wire

// ==== cmwc_pattern.sv ====
// Bus wake-up pattern detector
`include "cmwc_regs.svh"
`default_nettype none
module cmwc_pattern
  import cmwc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic enable_in,
  input wire logic bus_dom_in,
  input wire logic extended_in,
  output logic pattern_out
);
  localparam int DOM_CYC = `CMWC_CYC(`CMWC_BUSDOM_NS);
  localparam int REC_CYC = `CMWC_CYC(`CMWC_BUSREC_NS);
  localparam int TO_CYC = `CMWC_TO_WAKE_US * 20;
  logic [15:0] run_reg, run_next;
  logic [15:0] to_reg, to_next;
  logic [2:0] step_reg, step_next;
  logic last_reg, last_next;
  logic hit_reg, hit_next;
  // Run length includes this sample, so a level change never inherits the old run
  wire [15:0] run_cur = (bus_dom_in == last_reg) ? run_reg + 16'h1 : 16'h0;
  wire long_dom = bus_dom_in && (run_cur >= 16'(DOM_CYC - 1));
  wire long_rec = !bus_dom_in && (run_cur >= 16'(REC_CYC - 1));
  always_comb
  begin
    run_next = run_cur;
    last_next = bus_dom_in;
    step_next = step_reg;
    to_next = (step_reg == 3'h0) ? 16'h0 : to_reg + 16'h1;
    hit_next = 1'b0;
    // short intervals only restart the run count, never the step
    case (step_reg)
      3'h0: if (long_dom) step_next = 3'h1;
      3'h1: if (long_rec) step_next = 3'h2;
      3'h2: if (long_dom) step_next = 3'h3;
      3'h3:
      begin
        // extended pattern needs a trailing recessive phase
        if (!extended_in || long_rec)
        begin
          hit_next = 1'b1;
          step_next = 3'h0;
        end
      end
      default: step_next = 3'h0;
    endcase
    if (!enable_in || to_reg >= 16'(TO_CYC - 1))
    begin
      step_next = 3'h0;
      hit_next = 1'b0;
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      run_reg <= 16'h0;
      to_reg <= 16'h0;
      step_reg <= 3'h0;
      last_reg <= 1'b0;
      hit_reg <= 1'b0;
    end
    else
    begin
      run_reg <= run_next;
      to_reg <= to_next;
      step_reg <= step_next;
      last_reg <= last_next;
      hit_reg <= hit_next;
    end
  end
  assign pattern_out = hit_reg;
  // Timeout counter never passes its limit
  a_pattern_timeout: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    to_reg <= 16'(TO_CYC)) else $error("pattern timeout exceeded");
  // A hit only follows the final dominant phase
  sequence s_not_final;
    step_reg != 3'h3;
  endsequence
  a_pattern_order: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_not_final |=> !hit_reg) else $error("pattern hit out of order");
endmodule
`default_nettype wire

// ==== cmwc_bus_node.sv ====
// Partner node on the two-wire bus
`default_nettype none
module cmwc_bus_node
(
  input wire logic clk_in,
  output logic bus_dom_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bus idles recessive, as a released CAN bus does
  initial bus_dom_out = 1'b0;
  task automatic phase(input logic dom, input int n);
    @(negedge clk_in);
    bus_dom_out = dom;
    repeat (n - 1) @(negedge clk_in);
  endtask
  task automatic pattern(input logic glitch);
    phase(1'b1, 25);
    phase(1'b0, 25);
    if (glitch)
    begin
      phase(1'b1, 3);
      phase(1'b0, 25);
    end
    phase(1'b1, 25);
    phase(1'b0, 1);
  endtask
endmodule
`default_nettype wire

// ==== can_mode_and_wake_control_test.sv ====
// Self-checking bench of the CAN mode and wake control block
`default_nettype none
module can_mode_and_wake_control_test import cmwc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, rst_b_in, ot_forced_in, wake_pin_in, bus_dom_in, vcc_ok_in, txd_pin_in;
  logic sck_pin_in, sdi_pin_in, transmitter_enable_pin_in, irq_pending_in;
  logic rising_wake_enable_in, falling_wake_enable_in, wake_filter_select_in;
  logic selective_config_valid_in, selective_wake_enable_in, bus_wake_enable_in;
  logic bus_pattern_select_in, low_power_listen_in, bias_source_select_in;
  logic rxd_out, rxd_oe_out, pullup_en_out, txen_low_out, sck_rep_out, sdi_rep_out;
  logic supply_switch_output_out, spi_on_out, local_wake_on_out, bus_wake_on_out;
  logic pn_on_out, overtemp_on_out, wake_rising_irq_out, wake_falling_irq_out;
  logic local_wake_out, wake_pin_level_out, bus_idle_event_out, bus_wake_event_out;
  logic tx_on_out, tx_recessive_out, rx_on_out;
  logic [2:0] sys_mode_in, can_state_out;
  logic [1:0] bias_out;
  int errors = 0;
  int checked = 0;
  int cnt [4] = '{0, 0, 0, 0};
  cmwc_sys_t mode_tab [7] = '{CMWC_SYS_OFF, CMWC_SYS_BOOT, CMWC_SYS_CHECK,
    CMWC_SYS_STANDBY, CMWC_SYS_SLEEP, CMWC_SYS_LISTEN, CMWC_SYS_NORMAL};

  cmwc_top dut (.clk_in, .rst_b_in, .sys_mode_in, .ot_forced_in, .wake_pin_in, .bus_dom_in,
    .vcc_ok_in, .txd_pin_in, .sck_pin_in, .sdi_pin_in, .transmitter_enable_pin_in,
    .irq_pending_in, .rising_wake_enable_in, .falling_wake_enable_in, .wake_filter_select_in,
    .selective_config_valid_in, .selective_wake_enable_in, .bus_wake_enable_in,
    .bus_pattern_select_in, .low_power_listen_in, .bias_source_select_in, .rxd_out,
    .rxd_oe_out, .pullup_en_out, .txen_low_out, .sck_rep_out, .sdi_rep_out,
    .supply_switch_output_out, .spi_on_out, .local_wake_on_out, .bus_wake_on_out,
    .pn_on_out, .overtemp_on_out, .wake_rising_irq_out, .wake_falling_irq_out,
    .local_wake_out, .wake_pin_level_out, .bus_idle_event_out, .bus_wake_event_out,
    .can_state_out, .tx_on_out, .tx_recessive_out, .rx_on_out, .bias_out);
  cmwc_bus_node node (.clk_in(clk_in), .bus_dom_out(bus_dom_in));

  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Pulses stand one cycle, so they are counted at the edge
  always @(posedge clk_in)
  begin
    if (wake_rising_irq_out === 1'b1) cnt[0]++;
    if (wake_falling_irq_out === 1'b1) cnt[1]++;
    if (bus_wake_event_out === 1'b1) cnt[2]++;
    if (local_wake_out === 1'b1) cnt[3]++;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic summarize();
    $display("Counts: %0d errors, %0d checked", errors, checked);
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic go(input cmwc_sys_t m);
    @(negedge clk_in);
    sys_mode_in = m;
    repeat (4) @(negedge clk_in);
  endtask
  // Bounded wait for the next pulse of one counter
  task automatic wait_cnt(input int which, output int n);
    int start;
    start = cnt[which];
    n = 0;
    while (cnt[which] == start && n < 2000)
    begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 2000)
    begin
      errors++;
      summarize();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_modes();
    logic offg;
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 7; i++)
      begin
        @(negedge clk_in);
        selective_config_valid_in = s[0];
        {sck_pin_in, sdi_pin_in} = {s[0], !s[0]};
        sys_mode_in = mode_tab[i];
        @(negedge clk_in);
        offg = i < 3;
        check(txen_low_out, offg);
        check({pullup_en_out, rxd_oe_out}, {2{!offg}});
        check({sck_rep_out, sdi_rep_out}, {!offg && s == 1, !offg && s == 0});
        check({spi_on_out, local_wake_on_out}, {2{!offg}});
        check(bus_wake_on_out, (i == 3 || i == 4) && s == 0);
        check(pn_on_out, !offg && s == 1);
        check(overtemp_on_out, i == 6);
        check(supply_switch_output_out, !offg && i != 4);
      end
    selective_config_valid_in = 1'b0;
    go(CMWC_SYS_LISTEN);
    ot_forced_in = 1'b1;
    @(negedge clk_in);
    check(overtemp_on_out, 1'b1);
    ot_forced_in = 1'b0;
  endtask

  task automatic t_rxd();
    go(CMWC_SYS_STANDBY);
    irq_pending_in = 1'b1;
    repeat (3) @(negedge clk_in);
    check(rxd_out, 1'b0);
    irq_pending_in = 1'b0;
    repeat (3) @(negedge clk_in);
    check(rxd_out, 1'b1);
    go(CMWC_SYS_LISTEN);
    node.phase(1'b1, 5);
    check(rxd_out, 1'b0);
    node.phase(1'b0, 5);
    check(rxd_out, 1'b1);
  endtask

  task automatic t_can();
    go(CMWC_SYS_NORMAL);
    check(can_state_out, CMWC_CAN_ACTIVE);
    check({tx_on_out, tx_recessive_out, rx_on_out}, 3'h5);
    check(bias_out, CMWC_BIAS_VCC);
    transmitter_enable_pin_in = 1'b1;
    @(negedge clk_in);
    check(tx_recessive_out, 1'b1);
    go(CMWC_SYS_LISTEN);
    check(can_state_out, CMWC_CAN_LISTEN);
    check({tx_recessive_out, rx_on_out}, 2'h3);
    check(bias_out, CMWC_BIAS_VCC);
    low_power_listen_in = 1'b1;
    repeat (2) @(negedge clk_in);
    check({tx_on_out, rx_on_out}, 2'h1);
    check(bias_out, CMWC_BIAS_BAT);
    low_power_listen_in = 1'b0;
    go(CMWC_SYS_STANDBY);
    check(can_state_out, CMWC_CAN_BIAS);
    check({tx_on_out, rx_on_out}, 2'h0);
    check(bias_out, CMWC_BIAS_BAT);
    bias_source_select_in = 1'b1;
    @(negedge clk_in);
    check(bias_out, CMWC_BIAS_VCC);
    bias_source_select_in = 1'b0;
    go(CMWC_SYS_NORMAL);
    sys_mode_in = CMWC_SYS_OFF;
    vcc_ok_in = 1'b0;
    repeat (4) @(negedge clk_in);
    check(can_state_out, CMWC_CAN_OFF);
    check(bias_out, CMWC_BIAS_FLOAT);
    vcc_ok_in = 1'b1;
  endtask

  task automatic t_wake();
    int n;
    go(CMWC_SYS_STANDBY);
    rising_wake_enable_in = 1'b1;
    falling_wake_enable_in = 1'b1;
    // A glitch shorter than the filter must leave no trace
    wake_pin_in = 1'b1;
    repeat (100) @(negedge clk_in);
    wake_pin_in = 1'b0;
    repeat (300) @(negedge clk_in);
    check(cnt[0] + cnt[1], 8'h0);
    wake_pin_in = 1'b1;
    wait_cnt(0, n);
    check(n >= 200 && n <= 206, 1'b1);
    check(wake_pin_level_out, 1'b1);
    check(cnt[1], 8'h0);
    wake_filter_select_in = 1'b1;
    rising_wake_enable_in = 1'b0;
    wake_pin_in = 1'b0;
    wait_cnt(1, n);
    check(n >= 800 && n <= 806, 1'b1);
    check(wake_pin_level_out, 1'b0);
    wake_pin_in = 1'b1;
    repeat (900) @(negedge clk_in);
    check(cnt[0], 8'h1);
    check(wake_pin_level_out, 1'b1);
    check(cnt[3], 8'h2);
  endtask

  task automatic t_pattern();
    int e0;
    int n;
    e0 = cnt[2];
    check(bias_out, CMWC_BIAS_GND);
    node.pattern(1'b0);
    repeat (5) @(negedge clk_in);
    check(can_state_out, CMWC_CAN_BIAS);
    check(bias_out, CMWC_BIAS_BAT);
    check(cnt[2], e0);
    bus_wake_enable_in = 1'b1;
    node.pattern(1'b1);
    repeat (5) @(negedge clk_in);
    check(cnt[2], e0 + 1);
    bus_pattern_select_in = 1'b1;
    node.pattern(1'b0);
    repeat (5) @(negedge clk_in);
    check(cnt[2], e0 + 1);
    repeat (30) @(negedge clk_in);
    check(cnt[2], e0 + 2);
    bus_pattern_select_in = 1'b0;
    selective_config_valid_in = 1'b1;
    selective_wake_enable_in = 1'b1;
    node.pattern(1'b0);
    repeat (5) @(negedge clk_in);
    check(cnt[2], e0 + 2);
    selective_config_valid_in = 1'b0;
    selective_wake_enable_in = 1'b0;
    node.phase(1'b1, 25);
    node.phase(1'b0, 25);
    check(bus_idle_event_out, 1'b0);
    n = 0;
    while (bus_idle_event_out !== 1'b1 && n < 21000)
    begin
      @(negedge clk_in);
      n++;
    end
    check(n >= 19970 && n <= 20000, 1'b1);
    if (n >= 21000)
      summarize();
    @(negedge clk_in);
    check(can_state_out, CMWC_CAN_OFFLINE);
    check(bias_out, CMWC_BIAS_GND);
    // A pattern stretched past the timeout must not wake
    node.phase(1'b1, 25);
    node.phase(1'b0, 20010);
    node.phase(1'b1, 25);
    node.phase(1'b0, 5);
    check(cnt[2], e0 + 2);
    node.pattern(1'b0);
    repeat (5) @(negedge clk_in);
    check(cnt[2], e0 + 3);
  endtask

  initial
  begin
    {ot_forced_in, wake_pin_in, transmitter_enable_pin_in, irq_pending_in} = 4'h0;
    {rising_wake_enable_in, falling_wake_enable_in, wake_filter_select_in} = 3'h0;
    {selective_config_valid_in, selective_wake_enable_in, bus_wake_enable_in} = 3'h0;
    {bus_pattern_select_in, low_power_listen_in, bias_source_select_in} = 3'h0;
    {vcc_ok_in, txd_pin_in, sck_pin_in, sdi_pin_in} = 4'hf;
    sys_mode_in = CMWC_SYS_OFF;
    rst_b_in = 1'b0;
    repeat (3) @(negedge clk_in);
    rst_b_in = 1'b1;
    t_modes();
    t_rxd();
    t_can();
    t_wake();
    t_pattern();
    summarize();
  end
endmodule
`default_nettype wire
